/* hdl/asa_core.sv */
`timescale 1ns/100ps
module asa_core
    import asa_pkg::*;
#(
    parameter int unsigned COLS = ASA_COLS
) (
    // clock and synchronous reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // cpu i/o bus, one strobe cycle per access
    input  wire logic              io_read_strobe_i,
    input  wire logic              io_write_strobe_i,
    input  wire logic [7:0]        io_addr_i,
    input  wire logic [7:0]        io_wdata_i,
    // switched-capacitor address decode and raw read data
    input  wire logic              sc_sel_i,
    input  wire logic [1:0]        sc_col_i,
    input  wire logic [7:0]        sc_rdata_i,
    // column signals, asynchronous to the master clock
    input  wire logic [COLS-1:0]   comparator_i,
    input  wire logic [COLS-1:0]   phase_one_clock_i,
    input  wire logic [COLS-1:0]   phase_two_clock_i,
    // back to the cpu
    output logic [7:0]             io_rdata_o,
    output logic                   cpu_clk_hold_o,
    // write port into the analog array
    output logic                   sc_wr_o,
    output logic [7:0]             sc_waddr_o,
    output logic [7:0]             sc_wdata_o,
    // one pulse per column interrupt
    output logic [COLS-1:0]        column_irq_o
);
    // bus request as one bundle, and the copy parked during a stall
    asa_io_req_t     req;
    asa_io_req_t     held_ff;

    // stall machine
    asa_state_t      state_ff;
    asa_state_t      nxt_state;

    // control registers and the live step counter
    logic [7:0]      cmp_ctl_ff;
    logic [7:0]      asy_ff;
    logic [2:0]      step_ff;

    // three-stage synchronizers for the asynchronous column signals
    logic [COLS-1:0] cmp_s1_ff;
    logic [COLS-1:0] cmp_s2_ff;
    logic [COLS-1:0] cmp_s3_ff;
    logic [COLS-1:0] p1_s1_ff;
    logic [COLS-1:0] p1_s2_ff;
    logic [COLS-1:0] p1_s3_ff;
    logic [COLS-1:0] p2_s1_ff;
    logic [COLS-1:0] p2_s2_ff;
    logic [COLS-1:0] p2_s3_ff;

    // filtered levels and the phase-two comparator latch
    logic [COLS-1:0] cmp_st_ff;
    logic [COLS-1:0] p1_st_ff;
    logic [COLS-1:0] p2_st_ff;
    logic [COLS-1:0] cmp_lat_ff;

    // edge events and interrupt sources
    logic [COLS-1:0] p1_rise;
    logic [COLS-1:0] p2_fall;
    logic [COLS-1:0] irq_src;
    logic [COLS-1:0] irq_prev_ff;

    // approximation datapath
    logic            sar_cmp;
    logic            sar_active;
    logic [7:0]      sar_data;
    logic [7:0]      nxt_rdata;
    logic [1:0]      sar_col;
    logic [2:0]      prev_pos;

    // flatten the bus pins into one request word
    assign req = '{rd: io_read_strobe_i, wr: io_write_strobe_i, addr: io_addr_i,
                   wdata: io_wdata_i, sc_sel: sc_sel_i, sc_col: sc_col_i};

    // three-stage synchronizers; a change counts when stages two and three agree,
    // so a late first stage cannot fake an edge; costs three cycles of latency
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_s1_ff <= '0;
            cmp_s2_ff <= '0;
            cmp_s3_ff <= '0;
        end else begin
            cmp_s1_ff <= comparator_i;
            cmp_s2_ff <= cmp_s1_ff;
            cmp_s3_ff <= cmp_s2_ff;
        end
    end

    // phase-one chain, feeds the stall release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            p1_s1_ff  <= '0;
            p1_s2_ff  <= '0;
            p1_s3_ff  <= '0;
        end else begin
            p1_s1_ff  <= phase_one_clock_i;
            p1_s2_ff  <= p1_s1_ff;
            p1_s3_ff  <= p1_s2_ff;
        end
    end

    // phase-two chain, feeds the comparator latch and the clock-edge interrupt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            p2_s1_ff  <= '0;
            p2_s2_ff  <= '0;
            p2_s3_ff  <= '0;
        end else begin
            p2_s1_ff  <= phase_two_clock_i;
            p2_s2_ff  <= p2_s1_ff;
            p2_s3_ff  <= p2_s2_ff;
        end
    end

    // per-column filtered levels, edge detects and comparator latch
    genvar g;
    generate
        for (g = 0; g < COLS; g++) begin : g_col
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    cmp_st_ff[g]  <= 1'b0;
                    p1_st_ff[g]   <= 1'b0;
                    p2_st_ff[g]   <= 1'b0;
                    cmp_lat_ff[g] <= 1'b0;
                end else begin
                    // filtered levels move only when the last two stages agree
                    if (cmp_s2_ff[g] == cmp_s3_ff[g]) begin
                        cmp_st_ff[g] <= cmp_s3_ff[g];
                    end
                    if (p1_s2_ff[g] == p1_s3_ff[g]) begin
                        p1_st_ff[g] <= p1_s3_ff[g];
                    end
                    if (p2_s2_ff[g] == p2_s3_ff[g]) begin
                        p2_st_ff[g] <= p2_s3_ff[g];
                    end
                    // transparent while phase two high, holds while low
                    if (p2_st_ff[g]) begin
                        cmp_lat_ff[g] <= cmp_st_ff[g]; // [R6]
                    end
                end
            end
            // edges show one cycle before the filtered level follows them
            assign p1_rise[g] = (p1_s2_ff[g] == p1_s3_ff[g]) && p1_s3_ff[g] && !p1_st_ff[g];
            assign p2_fall[g] = (p2_s2_ff[g] == p2_s3_ff[g]) && !p2_s3_ff[g] && p2_st_ff[g];
            // comparator level, or a pulse on phase-two fall seen as rising
            assign irq_src[g] = cmp_ctl_ff[ASA_CMP_IRQ_LO + g] ? p2_fall[g] : cmp_lat_ff[g]; // [R4] [R5]
        end
    endgenerate

    // rising-edge interrupt to the controller, one cycle wide
    // limitation: a comparator already high at reset gives one pulse once it settles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_prev_ff  <= '0;
            column_irq_o <= '0;
        end else begin
            irq_prev_ff  <= irq_src;
            column_irq_o <= irq_src & ~irq_prev_ff; // [R4] [R5]
        end
    end

    // control registers; reserved bits ignored on write, read as zero
    // software should write zeros there anyway; they are dropped here regardless
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_ctl_ff <= ASA_RST_VAL; // [R19]
            asy_ff     <= ASA_RST_VAL; // [R19]
        end else if (req.wr && !req.sc_sel) begin
            if (req.addr == ASA_ADDR_CMP) begin
                cmp_ctl_ff <= {6'h00, req.wdata[ASA_CMP_IRQ_LO +: 2]};
            end else if (req.addr == ASA_ADDR_ASY) begin
                // field by field; the top bit is reserved and stays zero
                asy_ff <= {1'b0,
                           req.wdata[ASA_ASY_CNT_LO +: 3],
                           req.wdata[ASA_ASY_SIGN],
                           req.wdata[ASA_ASY_COL_LO +: 2],
                           req.wdata[ASA_ASY_SYNC]};
            end
        end
    end

    // approximation: counter selects guess bit, comparator corrects it
    // only the low column bit is decoded, as there are two columns
    assign sar_col    = asy_ff[ASA_ASY_COL_LO +: 2];
    assign sar_cmp    = cmp_lat_ff[sar_col[0]] ^ asy_ff[ASA_ASY_SIGN]; // [R15] [R16]
    assign sar_active = req.rd && req.sc_sel && (step_ff != ASA_CNT_ZERO); // [R10]
    assign prev_pos   = step_ff - ASA_CNT_ONE; // [R9]

    // step n rewrites bit n-1 and seeds bit n-2; counts above six
    // would touch bits that a six-bit converter does not use
    always_comb begin
        sar_data = sc_rdata_i;
        // comparator high means dac above input: guess too high
        sar_data[prev_pos] = !sar_cmp; // [R7] [R8]
        if (prev_pos != ASA_CNT_ZERO) begin
            sar_data[prev_pos - ASA_CNT_ONE] = 1'b1; // [R7]
        end
    end

    // step counter: loaded on control write, counts down per approximation read
    // a control write wins over a read in one cycle; the cpu never issues both
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            step_ff <= ASA_CNT_ZERO;
        end else if (req.wr && !req.sc_sel && req.addr == ASA_ADDR_ASY) begin
            step_ff <= req.wdata[ASA_ASY_CNT_LO +: 3]; // [R9]
        end else if (sar_active) begin
            step_ff <= step_ff - ASA_CNT_ONE; // [R18]
        end
    end

    // read mux; modified data formed in the read cycle itself, returned one cycle later
    // the counter reads back live, so software can watch a sequence finish
    always_comb begin
        nxt_rdata = 8'h00;
        if (req.rd && req.sc_sel) begin
            nxt_rdata = sar_active ? sar_data : sc_rdata_i; // [R13] [R10]
        end else if (req.rd && req.addr == ASA_ADDR_CMP) begin
            nxt_rdata = {2'b00, cmp_lat_ff, 2'b00, cmp_ctl_ff[ASA_CMP_IRQ_LO +: 2]}; // [R6]
        end else if (req.rd && req.addr == ASA_ADDR_ASY) begin
            nxt_rdata = {1'b0, step_ff, asy_ff[ASA_ASY_SIGN:ASA_ASY_SYNC]};
        end
    end

    // registered read data; the cpu takes it the cycle after its strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_rdata_o <= 8'h00;
        end else begin
            io_rdata_o <= nxt_rdata;
        end
    end

    // write stall machine; any cycle and phase accepted, wait is for the edge itself
    // column clocks run free, so a stall lasts at most one phase-one period
    // plus the synchronizer delay
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ASA_IDLE: begin
                if (req.wr && req.sc_sel && asy_ff[ASA_ASY_SYNC]) begin
                    nxt_state = ASA_STALL; // [R1] [R3]
                end
            end
            ASA_STALL: begin
                if (p1_rise[held_ff.sc_col[0]]) begin
                    nxt_state = ASA_IDLE; // [R2]
                end
            end
            default: nxt_state = ASA_IDLE;
        endcase
    end

    // the request is parked whenever a switched-cap write is taken from idle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ASA_IDLE;
            held_ff  <= '0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == ASA_IDLE && req.wr && req.sc_sel) begin
                held_ff <= req; // [R1]
            end
        end
    end

    // clock hold stops the whole cpu, interrupts included, until release
    // trade-off: cpu throughput is given up so the write lands on the quiet edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_clk_hold_o <= 1'b0;
        end else begin
            cpu_clk_hold_o <= (nxt_state == ASA_STALL); // [R17]
        end
    end

    // analog register write: direct when sync off, on release otherwise
    // address and data stay put after the pulse, so the array may sample late
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sc_wr_o    <= 1'b0;
            sc_waddr_o <= 8'h00;
            sc_wdata_o <= 8'h00;
        end else begin
            sc_wr_o <= 1'b0;
            if (state_ff == ASA_STALL && nxt_state == ASA_IDLE) begin
                sc_wr_o    <= 1'b1; // [R2]
                sc_waddr_o <= held_ff.addr;
                sc_wdata_o <= held_ff.wdata;
            end else if (state_ff == ASA_IDLE && req.wr && req.sc_sel && !asy_ff[ASA_ASY_SYNC]) begin
                sc_wr_o    <= 1'b1;
                sc_waddr_o <= req.addr;
                sc_wdata_o <= req.wdata;
            end
        end
    end
endmodule // asa_core

/* hdl/asa_pkg.sv */
// Operation
// [R1] with write sync enabled, writes to switched-capacitor registers are held and cpu stalled
// [R2] stall released on next phase-one rising edge of target column, then write performed
// [R3] writes accepted on any master clock edge, in any phase, no fixed relation assumed
// [R4] select bit clear: column interrupt is comparator bit, rising edge registers interrupt
// [R5] select bit set: phase-two falling edge becomes a rising interrupt signal
// [R6] comparator status bits are read-only and synchronized to column clock
// [R7] each approximation read overrides previous guess bit and sets next lower bit
// [R8] previous guess cleared when comparator says too high, else left set
// [R9] three-bit step counter loaded from step-count field decodes affected bit positions
// [R10] nonzero step count makes switched-capacitor reads approximation steps; zero passes data through
// [R11] software loads six steps and issues six read-modify-writes for six-bit conversion
// [R12] software initializes control register and sets sign bit as first guess
// [R13] modification applied to read data during read, write-back stores updated guess
// [R14] software writes zero to reserved bits
// [R15] column-select field picks which comparator feeds approximation logic
// [R16] sign-invert bit optionally inverts comparator before approximation logic
// [R17] stall done by suspending cpu clock, so no cpu activity during stall
// [R18] step counter decrements after each approximation read, passes through at zero
// [R19] both control registers reset to zero
package asa_pkg;
    localparam int unsigned ASA_COLS = 2;
    localparam logic [7:0] ASA_ADDR_CMP = 8'h64; // comparator_status_irq_select
    localparam logic [7:0] ASA_ADDR_ASY = 8'h65; // sync_and_approx_control
    localparam logic [7:0] ASA_RST_VAL  = 8'h00;
    localparam int unsigned ASA_CMP_COMP_LO = 4;
    localparam int unsigned ASA_CMP_IRQ_LO  = 0;
    localparam int unsigned ASA_ASY_SYNC    = 0;
    localparam int unsigned ASA_ASY_COL_LO  = 1;
    localparam int unsigned ASA_ASY_SIGN    = 3;
    localparam int unsigned ASA_ASY_CNT_LO  = 4;
    localparam logic [2:0] ASA_CNT_ZERO = 3'h0;
    localparam logic [2:0] ASA_CNT_ONE  = 3'h1;
    localparam logic [2:0] ASA_CNT_TOP  = 3'h6; // six-bit converter sign bit sits at bit 5

    // cpu i/o bus request as seen by the interface
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       sc_sel;  // address decodes to a switched-capacitor register
        logic [1:0] sc_col;  // column of that register
    } asa_io_req_t;

    typedef enum logic [0:0] {
        ASA_IDLE  = 1'b0,
        ASA_STALL = 1'b1
    } asa_state_t;
endpackage

/* test/asa_col_model.sv */
`timescale 1ns/100ps
module asa_col_model (
    input  wire logic       clk_i,
    input  wire logic       sc_wr_i,
    input  wire logic [7:0] sc_wdata_i,
    input  wire logic [5:0] vin_i,
    output logic [1:0]      phase_one_clock_o,
    output logic [1:0]      phase_two_clock_o,
    output logic [1:0]      comparator_o,
    output logic [7:0]      sc_rdata_o
);
    logic [4:0] ph_ff  = 5'h00;
    logic [7:0] cap_ff = 8'h00;
    // column clock, period 24, dead band between the phases
    always_ff @(posedge clk_i) begin
        ph_ff <= (ph_ff == 5'h17) ? 5'h00 : ph_ff + 5'h01;
    end
    assign phase_one_clock_o = {2{ph_ff < 5'h08}};
    assign phase_two_clock_o = {2{ph_ff >= 5'h0c && ph_ff < 5'h14}};
    // dac register takes every switched-cap write
    always_ff @(posedge clk_i) begin
        if (sc_wr_i) begin
            cap_ff <= sc_wdata_i;
        end
    end
    // column 1 has the opposite sense, so column select shows in the result
    assign comparator_o = {~(cap_ff[5:0] > vin_i), cap_ff[5:0] > vin_i};
    assign sc_rdata_o   = cap_ff;
endmodule // asa_col_model

/* test/asa_core_sva.sv */
`timescale 1ns/100ps
module asa_core_sva
    import asa_pkg::*;
#(
    parameter int unsigned COLS = ASA_COLS
) (
    input wire logic            clk_i,
    input wire logic            rst_i,
    input wire logic            io_read_strobe_i,
    input wire logic            io_write_strobe_i,
    input wire logic [7:0]      io_addr_i,
    input wire logic [7:0]      io_wdata_i,
    input wire logic            sc_sel_i,
    input wire logic [1:0]      sc_col_i,
    input wire logic [7:0]      sc_rdata_i,
    input wire logic [COLS-1:0] comparator_i,
    input wire logic [COLS-1:0] phase_one_clock_i,
    input wire logic [COLS-1:0] phase_two_clock_i,
    input wire logic [7:0]      io_rdata_o,
    input wire logic            cpu_clk_hold_o,
    input wire logic            sc_wr_o,
    input wire logic [7:0]      sc_waddr_o,
    input wire logic [7:0]      sc_wdata_o,
    input wire logic [COLS-1:0] column_irq_o
);
    logic       sync_ff;
    logic [2:0] cnt_ff;
    logic       wr_asy, rd_sc, sc_w;
    logic [7:0] gbit;
    assign sc_w   = io_write_strobe_i && sc_sel_i && !cpu_clk_hold_o;
    assign wr_asy = io_write_strobe_i && !sc_sel_i && io_addr_i == ASA_ADDR_ASY && !cpu_clk_hold_o;
    assign rd_sc  = io_read_strobe_i && sc_sel_i && !cpu_clk_hold_o;
    assign gbit   = 8'h01 << (cnt_ff - 3'h2);
    // shadow of sync enable and step counter, rebuilt from bus traffic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_ff <= 1'b0;
        end else if (wr_asy) begin
            sync_ff <= io_wdata_i[ASA_ASY_SYNC];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= ASA_CNT_ZERO;
        end else if (wr_asy) begin
            cnt_ff <= io_wdata_i[ASA_ASY_CNT_LO +: 3];
        end else if (rd_sc && cnt_ff != ASA_CNT_ZERO) begin
            cnt_ff <= cnt_ff - ASA_CNT_ONE;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_reset_clears: assert property (disable iff (1'b0) rst_i |=> !cpu_clk_hold_o && !sc_wr_o)
        else $error("outputs not cleared in reset");
    chk_sync_stall: assert property (sc_w && sync_ff |=> cpu_clk_hold_o && !sc_wr_o)
        else $error("synced write did not stall");
    chk_direct_write: assert property (sc_w && !sync_ff |=> sc_wr_o && sc_wdata_o == $past(io_wdata_i))
        else $error("plain write not performed");
    chk_release_write: assert property ($fell(cpu_clk_hold_o) |-> sc_wr_o)
        else $error("release without held write");
    chk_stall_bound: assert property ($rose(cpu_clk_hold_o) |-> ##[1:40] !cpu_clk_hold_o)
        else $error("stall too long");
    chk_pass_read: assert property (rd_sc && cnt_ff == 3'h0 |=> io_rdata_o == $past(sc_rdata_i))
        else $error("read data modified at zero count");
    chk_guess_next: assert property (rd_sc && cnt_ff >= 3'h2 |=> (io_rdata_o & $past(gbit)) != 8'h00)
        else $error("next guess bit not set");
    chk_status_reserved: assert property (io_read_strobe_i && !sc_sel_i && io_addr_i == ASA_ADDR_CMP
        |=> (io_rdata_o & 8'hcc) == 8'h00)
        else $error("reserved status bits not zero");
    chk_irq_single: assert property (column_irq_o[0] |=> !column_irq_o[0])
        else $error("interrupt pulse too long");
    cov_stall: cover property ($fell(cpu_clk_hold_o));
    cov_sar: cover property (rd_sc && cnt_ff == ASA_CNT_ONE);
    cov_irq: cover property (column_irq_o[1]);
endmodule // asa_core_sva
bind asa_core asa_core_sva #(.COLS(COLS)) SVA (.clk_i(clk_i), .rst_i(rst_i), .io_read_strobe_i(io_read_strobe_i),
    .io_write_strobe_i(io_write_strobe_i), .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i), .sc_sel_i(sc_sel_i),
    .sc_col_i(sc_col_i), .sc_rdata_i(sc_rdata_i), .comparator_i(comparator_i), .phase_one_clock_i(phase_one_clock_i),
    .phase_two_clock_i(phase_two_clock_i), .io_rdata_o(io_rdata_o), .cpu_clk_hold_o(cpu_clk_hold_o),
    .sc_wr_o(sc_wr_o), .sc_waddr_o(sc_waddr_o), .sc_wdata_o(sc_wdata_o), .column_irq_o(column_irq_o));

/* test/testbench.sv */
`timescale 1ns/100ps
module testbench;
    import asa_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    asa_io_req_t req   = '0;
    logic [7:0]  rdata, sc_rdata, sc_waddr, sc_wdata, d;
    logic [1:0]  cmp, ph1, ph2, irq;
    logic        hold, sc_wr;
    logic [5:0]  vin = 6'h00;
    int          miscompares = 0;
    int          checks = 0;
    int          cyc = 0;
    int          n0, n1;
    asa_core DUT (.clk_i(clk_i), .rst_i(rst_i), .io_read_strobe_i(req.rd), .io_write_strobe_i(req.wr),
        .io_addr_i(req.addr), .io_wdata_i(req.wdata), .sc_sel_i(req.sc_sel), .sc_col_i(req.sc_col),
        .sc_rdata_i(sc_rdata), .comparator_i(cmp), .phase_one_clock_i(ph1), .phase_two_clock_i(ph2),
        .io_rdata_o(rdata), .cpu_clk_hold_o(hold), .sc_wr_o(sc_wr), .sc_waddr_o(sc_waddr),
        .sc_wdata_o(sc_wdata), .column_irq_o(irq));
    asa_col_model PEER (.clk_i(clk_i), .sc_wr_i(sc_wr), .sc_wdata_i(sc_wdata), .vin_i(vin),
        .phase_one_clock_o(ph1), .phase_two_clock_o(ph2), .comparator_o(cmp), .sc_rdata_o(sc_rdata));
    initial forever #4 clk_i = ~clk_i;
    // watchdog, well above the roughly 1300 cycles the tests need
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // one bus cycle; read data is registered, so it is taken one edge later
    task automatic io(input logic w, input logic sc, input logic [7:0] a, input logic [7:0] wd);
        @(negedge clk_i);
        req = '{rd: !w, wr: w, addr: a, wdata: wd, sc_sel: sc, sc_col: 2'h0};
        @(negedge clk_i);
        req.rd = 1'b0;
        req.wr = 1'b0;
        d = rdata;
    endtask
    // software reference of the binary search, comparator high means too high
    function automatic logic [7:0] sar_ref(input logic [5:0] v, input logic inv);
        logic [7:0] g;
        g = 8'h20;
        for (int i = 5; i >= 0; i--) begin
            if ((g[5:0] > v) ^ inv) g[i] = 1'b0;
            if (i > 0) g[i-1] = 1'b1;
        end
        return g;
    endfunction
    // long gaps let the latched comparator follow each write-back
    task automatic sar(input logic col, input logic inv);
        io(1'b1, 1'b1, 8'h80, 8'h20);
        io(1'b1, 1'b0, ASA_ADDR_ASY, {1'b0, ASA_CNT_TOP, inv, 1'b0, col, 1'b0});
        // six read-modify-writes, then a plain read of the result
        repeat (6) begin
            repeat (40) @(negedge clk_i);
            io(1'b0, 1'b1, 8'h80, 8'h00);
            io(1'b1, 1'b1, 8'h80, d);
        end
        io(1'b0, 1'b1, 8'h80, 8'h00);
        check("sar result", d, sar_ref(vin, col ^ inv));
        io(1'b0, 1'b0, ASA_ADDR_ASY, 8'h00);
        check("step count", d, {4'h0, inv, 1'b0, col, 1'b0});
    endtask
    initial begin
        repeat (16) @(negedge clk_i);
        rst_i = 1'b0;
        io(1'b0, 1'b0, ASA_ADDR_CMP, 8'h00);
        check("status reset", d & 8'hcf, 8'h00);
        io(1'b0, 1'b0, ASA_ADDR_ASY, 8'h00);
        check("control reset", d, 8'h00);
        vin = 6'h2b;
        for (int k = 0; k < 4; k++) sar(k[1], k[0]);
        vin = 6'h00;
        io(1'b1, 1'b0, ASA_ADDR_CMP, 8'h01);
        repeat (48) @(negedge clk_i);
        vin = 6'h3f;
        n0 = 0;
        n1 = 0;
        repeat (48) begin
            @(negedge clk_i);
            n0 += irq[0];
            n1 += irq[1];
        end
        check("irq phase two", n0[7:0], 8'h02);
        check("irq comparator", n1[7:0], 8'h01);
        io(1'b0, 1'b0, ASA_ADDR_CMP, 8'h00);
        check("status", d, 8'h21);
        io(1'b1, 1'b0, ASA_ADDR_ASY, 8'h01);
        io(1'b1, 1'b1, 8'h80, 8'h15);
        check("stall", {7'h00, hold}, 8'h01);
        for (n0 = 0; n0 < 100 && hold !== 1'b0; n0++) @(negedge clk_i);
        check("release", {sc_wr, ph1[0], 6'h00}, 8'hc0);
        check("held data", sc_wdata, 8'h15);
        check("held addr", sc_waddr, 8'h80);
        tally_and_finish();
    end
endmodule // testbench
